/* File: logic/tpc_pkg.sv */
// What this block does
// - Eight channels, one pin each
// - Clock select: off, bus, fixed, external pin
// - External clock synchronised; must stay at or below quarter rate
// - Output compare works as software timer on clock
// - Pin released when edge select or clock off
// - Reset disables all timer pin functions
// - Center select drives every enabled channel pin
// - Mode select picks capture, compare or PWM
// - Capture pin is edge input, edge select polarity
// - Capture input synchronised, four-clock pulses caught
// - Compare match toggles, clears or sets pin
// - Toggle first keeps previous level until match
// - Edge PWM drives pin, low bit sets polarity
// - Edge PWM high-true: high at zero, low match
// - Edge PWM low-true: pin high on match
// - Center PWM drives all enabled pins, low bit polarity
// - Center high-true: clear up match, set down
// - Center counter counts up to modulo, down
// - Edge PWM period is modulo plus one
package tpc_pkg;
    localparam int NUM_CH = 8; // Channel count
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00; // Clock, prescale, center
    localparam logic [7:0] OFF_COUNT = 8'h04; // Counter, write resets
    localparam logic [7:0] OFF_MOD = 8'h08; // Modulo value
    localparam logic [7:0] OFF_CH_BASE = 8'h10; // First channel control
    localparam logic [7:0] OFF_CH_END = 8'h50; // Past last channel
    localparam int CH_STRIDE_SHIFT = 3; // Eight bytes per channel
    // Control register fields
    localparam int CTRL_PS_LSB = 0; // Prescale, 3 bits
    localparam int CTRL_CLKS_LSB = 3; // Clock source, 2 bits
    localparam int CTRL_CPWM_BIT = 5; // Center-aligned select
    // Channel control fields
    localparam int CH_ELS_LSB = 2; // Edge/level select, 2 bits
    localparam int CH_MS_LSB = 4; // Mode select, 2 bits
    localparam int CH_FLAG_BIT = 7; // Event flag, write 1 clears
    // Reset values
    localparam logic [15:0] MOD_RESET = 16'h0000; // Free running
    localparam logic [15:0] VAL_RESET = 16'h0000; // Channel value
    // Clock source encodings
    localparam logic [1:0] CLKS_OFF = 2'h0; // No clock
    localparam logic [1:0] CLKS_BUS = 2'h1; // Bus rate
    localparam logic [1:0] CLKS_FIXED = 2'h2; // Crystal derived
    localparam logic [1:0] CLKS_EXT = 2'h3; // External pin
    // Timing in bus clocks
    localparam int EXT_MIN_RATIO = 4; // Ext clock at most quarter rate
    localparam int CAPT_MIN_PULSE = 4; // Reliable capture pulse
endpackage

/* File: logic/tpc_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser with edge detection on the settled copy
module tpc_sync #(
    parameter int W = 1 // Number of bits
) (
    input wire logic mclk_i, // Bus clock
    input wire logic rst_n_i, // Sync reset, active low
    input wire logic [W-1:0] async_i, // Raw pin levels
    output logic [W-1:0] level_o, // Synchronised level
    output logic [W-1:0] rise_o, // One-cycle rising pulse
    output logic [W-1:0] fall_o // One-cycle falling pulse
);
    logic [W-1:0] meta; // First stage, read only by second
    logic [W-1:0] stable; // Second stage
    logic [W-1:0] prev; // Edge-detect history
    // Three flops: two settle, one remembers
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            meta <= '0;
            stable <= '0;
            prev <= '0;
        end else begin
            meta <= async_i;
            stable <= meta;
            prev <= stable;
        end
    end
    assign level_o = stable;
    assign rise_o = stable & ~prev;
    assign fall_o = ~stable & prev;
endmodule

/* File: logic/tpc_channel.sv */
`timescale 1ns/1ps
// One timer channel: capture, compare, edge and center PWM pin logic
module tpc_channel (
    input wire logic mclk_i, // Bus clock
    input wire logic rst_n_i, // Sync reset, active low
    input wire logic tick_i, // Counter advances this cycle
    input wire logic restart_i, // Counter goes to zero this tick
    input wire logic counting_up_i, // Counter direction
    input wire logic [15:0] counter_i, // Timer counter value
    input wire logic [15:0] value_i, // Channel value
    input wire logic center_aligned_select_i, // Module-wide center mode
    input wire logic clock_off_i, // Clock source is none
    input wire logic [1:0] channel_mode_select_i, // Channel mode
    input wire logic [1:0] edge_level_select_i, // Edge/level select
    input wire logic pin_level_i, // Synchronised pin level
    input wire logic pin_rise_i, // Synchronised rising edge
    input wire logic pin_fall_i, // Synchronised falling edge
    output logic channel_pin_o, // Driven pin level
    output logic channel_pin_oe_o, // Timer drives pin
    output logic channel_owns_o, // Pin taken from port logic
    output logic capture_o, // Capture strobe
    output logic event_o // Flag-setting event
);
    logic pin_q; // Output level register
    logic next_pin; // Next output level
    wire els_on = edge_level_select_i != 2'h0; // Function enabled
    wire active = els_on && !clock_off_i;
    wire cfg_ic = !center_aligned_select_i
        && channel_mode_select_i == 2'h0;
    wire cfg_oc = !center_aligned_select_i
        && channel_mode_select_i == 2'h1;
    wire cfg_epwm = !center_aligned_select_i
        && channel_mode_select_i[1];
    wire drive = active && !cfg_ic;
    wire match = tick_i && counter_i == value_i; // Compare hit
    // Edge PWM acts as the counter lands on the value, like restart
    wire [15:0] count_next = restart_i ? 16'h0000
        : 16'(counter_i + 16'h0001); // Counter after this tick
    wire pwm_hit = tick_i && count_next == value_i;
    wire els_low = edge_level_select_i[0]; // Polarity bit
    // Capture edges: 01 rising, 10 falling, 11 either
    wire cap_hit = (edge_level_select_i[0] && pin_rise_i)
        || (edge_level_select_i[1] && pin_fall_i);
    assign capture_o = active && cfg_ic && cap_hit;
    // Compare still flags with pin released: software timer
    assign event_o = cfg_ic ? capture_o : match;
    assign channel_pin_oe_o = drive;
    assign channel_owns_o = active;
    assign channel_pin_o = pin_q;
    // Output level selection
    always_comb begin
        next_pin = pin_q;
        if (!drive) begin
            // Track pin so toggle starts from the old level
            next_pin = pin_level_i;
        end else if (center_aligned_select_i) begin
            if (match) begin
                next_pin = counting_up_i ? els_low : !els_low;
            end
        end else if (cfg_epwm) begin
            if (pwm_hit) begin
                next_pin = els_low;
            end else if (restart_i) begin
                next_pin = !els_low;
            end
        end else if (cfg_oc && match) begin
            case (edge_level_select_i)
                2'h1: next_pin = !pin_q;
                2'h2: next_pin = 1'b0; // Clear on match
                default: next_pin = 1'b1; // Set on match
            endcase
        end
    end
    // Pin register
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= next_pin;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    a_toggle_match: assert property (
        drive && cfg_oc && edge_level_select_i == 2'h1 && match
        |=> channel_pin_o == !$past(channel_pin_o))
        else $error("toggle on compare failed");
    a_epwm_start: assert property (
        drive && cfg_epwm && edge_level_select_i == 2'h2
        && restart_i && !pwm_hit |=> channel_pin_o)
        else $error("edge PWM not high at period start");
    a_capture_mode: assert property (
        capture_o |-> cfg_ic && !channel_pin_oe_o)
        else $error("capture outside capture mode");
    c_capture: cover property (capture_o);
    c_center_match: cover property (drive && center_aligned_select_i
        && match);
endmodule

/* File: logic/tpc_top.sv */
`timescale 1ns/1ps
// Timer channel pin control with Avalon-MM register slave
module tpc_top (
    input wire logic mclk_i, // Bus clock, 100 MHz
    input wire logic rst_n_i, // Sync reset, active low
    input wire logic [7:0] address_i, // Byte address
    input wire logic read_i, // Read request
    input wire logic write_i, // Write request
    input wire logic [3:0] byteenable_i, // Byte lanes
    input wire logic [31:0] writedata_i, // Write data
    output logic [31:0] readdata_o, // Read data
    output logic waitrequest_o, // Slave not ready
    input wire logic fixed_clock_i, // Crystal-derived clock
    input wire logic external_count_clock_pin_i, // External clock
    input wire logic [7:0] channel_pin_i, // Pin levels in
    output logic [7:0] channel_pin_o, // Pin levels out
    output logic [7:0] channel_pin_oe_o, // Pin drive enables
    output logic [7:0] channel_owns_pin_o, // Pin taken from GPIO
    output logic [7:0] channel_event_flag_o, // Sticky event flags
    output logic counter_overflow_flag_o // Sticky overflow flag
);
    localparam int N = tpc_pkg::NUM_CH; // Channel count

    // Software-visible state
    logic [2:0] prescale; // Divide by 2^n
    logic [1:0] clock_source_select; // Counter clock source
    logic center_aligned_select; // All channels center PWM
    logic [15:0] modulo; // Counter modulo
    logic [15:0] timer_counter; // Running counter
    logic counting_up; // Center mode direction
    logic [6:0] prescale_count; // Prescaler divider
    logic overflow_flag; // Sticky overflow
    logic [1:0] channel_mode_select [N]; // Per-channel mode
    logic [1:0] edge_level_select [N]; // Per-channel edge/level
    logic [15:0] channel_value [N]; // Per-channel value
    logic [N-1:0] event_flag; // Per-channel sticky flag

    // Bus handshake state
    logic ack; // Second cycle of an access

    // Synchronised pins
    logic [N-1:0] pin_level; // Channel pin levels
    logic [N-1:0] pin_rise; // Channel pin rising edges
    logic [N-1:0] pin_fall; // Channel pin falling edges
    logic [1:0] clk_level; // Fixed and external levels
    logic [1:0] clk_rise; // Fixed and external rising edges

    // Per-channel results
    logic [N-1:0] capture; // Capture strobes
    logic [N-1:0] chan_event; // Flag-setting events

    // Capture pins through a bus-clock synchroniser
    tpc_sync #(.W(N)) u_pin_sync (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .async_i(channel_pin_i),
        .level_o(pin_level),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    // Clock sources synchronised the same way; only rising edges count
    tpc_sync #(.W(2)) u_clk_sync (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .async_i({external_count_clock_pin_i, fixed_clock_i}),
        .level_o(clk_level),
        .rise_o(clk_rise),
        .fall_o()
    );

    // Source tick selection
    wire src_tick = (clock_source_select == tpc_pkg::CLKS_BUS)
        || (clock_source_select == tpc_pkg::CLKS_FIXED && clk_rise[0])
        || (clock_source_select == tpc_pkg::CLKS_EXT
            && clk_rise[1]);
    wire clock_off = clock_source_select == tpc_pkg::CLKS_OFF;
    // Prescaler tap: all low bits set means the divided edge
    wire [6:0] ps_mask = 7'(({7'h01} << prescale) - 7'h01);
    wire tick = src_tick && ((prescale_count & ps_mask) == ps_mask);

    // Counter next-value decode
    // Free-run modulo values ignore the top; center mode must avoid them
    wire at_mod = timer_counter == modulo; // Reached modulo
    wire free_wrap = modulo == 16'h0000 || modulo == 16'hFFFF;
    wire edge_wrap = free_wrap ? timer_counter == 16'hFFFF : at_mod;
    wire up_turn = counting_up && at_mod && !free_wrap; // Top turn
    wire down_turn = !counting_up && timer_counter == 16'h0001;
    wire restart = tick && (center_aligned_select ? down_turn
        : edge_wrap); // Counter becomes zero
    wire [15:0] counter_step = center_aligned_select
        ? (counting_up && !up_turn ? timer_counter + 16'h0001
            : timer_counter - 16'h0001)
        : (edge_wrap ? 16'h0000 : timer_counter + 16'h0001);

    // Bus decode
    // Offsets outside the map fall through and read as zero
    wire access = read_i || write_i; // Request present
    wire take = access && ack; // Edge where the access completes
    wire hit_ctrl = address_i == tpc_pkg::OFF_CTRL;
    wire hit_count = address_i == tpc_pkg::OFF_COUNT;
    wire hit_mod = address_i == tpc_pkg::OFF_MOD;
    wire hit_ch = address_i >= tpc_pkg::OFF_CH_BASE
        && address_i < tpc_pkg::OFF_CH_END && address_i[1:0] == 2'h0;
    wire [7:0] ch_off = address_i - tpc_pkg::OFF_CH_BASE;
    wire [2:0] ch_idx = ch_off[tpc_pkg::CH_STRIDE_SHIFT +: 3];
    wire ch_is_val = ch_off[2]; // Second word of channel pair
    wire wr = take && write_i; // Write commits
    wire wr_ctrl = wr && hit_ctrl && byteenable_i[0];
    wire wr_count = wr && hit_count && byteenable_i[1:0] != 2'h0;
    wire wr_mod = wr && hit_mod;
    wire wr_ch_ctl = wr && hit_ch && !ch_is_val && byteenable_i[0];
    wire wr_ch_val = wr && hit_ch && ch_is_val;
    wire ovf_clear = wr_ctrl && writedata_i[7]; // Write 1 clears

    // Merge a 16-bit register with enabled write lanes
    function automatic logic [15:0] lane16(input logic [15:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        lane16 = old;
        if (be[0]) begin
            lane16[7:0] = wd[7:0];
        end
        if (be[1]) begin
            lane16[15:8] = wd[15:8];
        end
    endfunction

    // Read multiplexer
    logic [31:0] read_mux; // Word for current address
    always_comb begin
        read_mux = 32'h00000000;
        if (hit_ctrl) begin
            read_mux[7] = overflow_flag;
            read_mux[tpc_pkg::CTRL_CPWM_BIT] = center_aligned_select;
            read_mux[tpc_pkg::CTRL_CLKS_LSB +: 2] = clock_source_select;
            read_mux[tpc_pkg::CTRL_PS_LSB +: 3] = prescale;
        end else if (hit_count) begin
            read_mux[15:0] = timer_counter;
        end else if (hit_mod) begin
            read_mux[15:0] = modulo;
        end else if (hit_ch && ch_is_val) begin
            read_mux[15:0] = channel_value[ch_idx];
        end else if (hit_ch) begin
            read_mux[tpc_pkg::CH_FLAG_BIT] = event_flag[ch_idx];
            read_mux[tpc_pkg::CH_MS_LSB +: 2] = channel_mode_select[ch_idx];
            read_mux[tpc_pkg::CH_ELS_LSB +: 2] = edge_level_select[ch_idx];
        end
    end

    // One wait state on every access; unmapped reads give zero
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ack <= 1'b0;
            readdata_o <= 32'h00000000;
        end else begin
            ack <= access && !ack;
            if (access && !ack) begin
                readdata_o <= read_mux;
            end
        end
    end
    assign waitrequest_o = access && !ack;

    // Module control registers; reset leaves the clock off
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            prescale <= 3'h0;
            clock_source_select <= tpc_pkg::CLKS_OFF;
            center_aligned_select <= 1'b0;
            modulo <= tpc_pkg::MOD_RESET;
        end else begin
            if (wr_ctrl) begin
                prescale <= writedata_i[tpc_pkg::CTRL_PS_LSB +: 3];
                clock_source_select <=
                    writedata_i[tpc_pkg::CTRL_CLKS_LSB +: 2];
                center_aligned_select <=
                    writedata_i[tpc_pkg::CTRL_CPWM_BIT];
            end
            if (wr_mod) begin
                modulo <= lane16(modulo, writedata_i, byteenable_i);
            end
        end
    end

    // Prescaler and counter; a count write enabling byte lane 0 or 1 resets the counter
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            prescale_count <= 7'h00;
            timer_counter <= 16'h0000;
            counting_up <= 1'b1;
        end else if (wr_count || clock_off) begin
            prescale_count <= 7'h00;
            timer_counter <= wr_count ? 16'h0000 : timer_counter;
            counting_up <= wr_count ? 1'b1 : counting_up;
        end else begin
            if (src_tick) begin
                prescale_count <= prescale_count + 7'h01;
            end
            if (tick) begin
                timer_counter <= counter_step;
                if (up_turn) begin
                    counting_up <= 1'b0;
                end else if (restart) begin
                    counting_up <= 1'b1;
                end
            end
        end
    end

    // Overflow flag: set wins over clear
    wire ovf_event = center_aligned_select ? (tick && up_turn) : restart;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            overflow_flag <= 1'b0;
        end else if (ovf_event) begin
            overflow_flag <= 1'b1;
        end else if (ovf_clear) begin
            overflow_flag <= 1'b0;
        end
    end
    assign counter_overflow_flag_o = overflow_flag;

    // Channel registers; capture loads the counter into the value
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < N; i++) begin
                channel_mode_select[i] <= 2'h0;
                edge_level_select[i] <= 2'h0;
                channel_value[i] <= tpc_pkg::VAL_RESET;
                event_flag[i] <= 1'b0;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (wr_ch_ctl && ch_idx == 3'(i)) begin
                    channel_mode_select[i] <=
                        writedata_i[tpc_pkg::CH_MS_LSB +: 2];
                    edge_level_select[i] <=
                        writedata_i[tpc_pkg::CH_ELS_LSB +: 2];
                end
                if (capture[i]) begin
                    channel_value[i] <= timer_counter;
                end else if (wr_ch_val && ch_idx == 3'(i)) begin
                    channel_value[i] <= lane16(channel_value[i],
                        writedata_i, byteenable_i);
                end
                // Hardware event beats a same-cycle clear
                if (chan_event[i]) begin
                    event_flag[i] <= 1'b1;
                end else if (wr_ch_ctl && ch_idx == 3'(i)
                    && writedata_i[tpc_pkg::CH_FLAG_BIT]) begin
                    event_flag[i] <= 1'b0;
                end
            end
        end
    end
    assign channel_event_flag_o = event_flag;

    // One channel per pin
    for (genvar g = 0; g < N; g++) begin : g_ch
        tpc_channel u_ch (
            .mclk_i(mclk_i),
            .rst_n_i(rst_n_i),
            .tick_i(tick),
            .restart_i(restart),
            .counting_up_i(counting_up),
            .counter_i(timer_counter),
            .value_i(channel_value[g]),
            .center_aligned_select_i(center_aligned_select),
            .clock_off_i(clock_off),
            .channel_mode_select_i(channel_mode_select[g]),
            .edge_level_select_i(edge_level_select[g]),
            .pin_level_i(pin_level[g]),
            .pin_rise_i(pin_rise[g]),
            .pin_fall_i(pin_fall[g]),
            .channel_pin_o(channel_pin_o[g]),
            .channel_pin_oe_o(channel_pin_oe_o[g]),
            .channel_owns_o(channel_owns_pin_o[g]),
            .capture_o(capture[g]),
            .event_o(chan_event[g])
        );
    end

    // Checks on pin ownership, the shared counter and bus state
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    a_reset_release: assert property (
        $rose(rst_n_i) |-> channel_owns_pin_o == 8'h00)
        else $error("pin owned right after reset");
    a_release_gpio: assert property (
        clock_off |-> channel_owns_pin_o == 8'h00
        && channel_pin_oe_o == 8'h00)
        else $error("pin held with clock off");
    a_center_drive: assert property (
        center_aligned_select && !clock_off && edge_level_select[0] != 2'h0
        |-> channel_pin_oe_o[0])
        else $error("center mode pin not driven");
    a_center_turn: assert property (
        center_aligned_select && tick && up_turn && !wr_count
        |=> !counting_up && timer_counter == $past(modulo) - 16'h0001)
        else $error("center counter did not turn down");
    a_edge_period: assert property (
        !center_aligned_select && tick && at_mod && !free_wrap
        && !wr_count |=> timer_counter == 16'h0000)
        else $error("edge counter did not wrap at modulo");
    a_clock_none: assert property (
        clock_off && !wr_count |=> $stable(timer_counter))
        else $error("counter moved with no clock");
    a_ext_spacing: assert property (
        clock_source_select == tpc_pkg::CLKS_EXT && src_tick
        |=> !clk_rise[1])
        else $error("external ticks back to back");
    a_bus_answer: assert property (
        access && !ack |=> ack && !waitrequest_o)
        else $error("bus answer not after one wait");
    a_wait_first: assert property (
        access && !ack |-> waitrequest_o)
        else $error("no wait state on new request");
    // Housekeeping: flags, counter reset and step, capture load, prescaler, drive ownership
    a_flag_set_wins: assert property (
        chan_event[0] |=> event_flag[0])
        else $error("channel flag lost to a clear");
    a_flag_sticky: assert property (
        event_flag[0] && !(wr_ch_ctl && ch_idx == 3'h0
        && writedata_i[tpc_pkg::CH_FLAG_BIT]) |=> event_flag[0])
        else $error("channel flag dropped by itself");
    a_ovf_sticky: assert property (
        ovf_event |=> overflow_flag)
        else $error("overflow flag not set");
    a_count_reset: assert property (
        wr_count |=> timer_counter == 16'h0000 && counting_up)
        else $error("count write did not reset counter");
    a_capture_load: assert property (
        capture[2] |=> channel_value[2] == $past(timer_counter))
        else $error("capture did not load counter");
    a_edge_step: assert property (
        !center_aligned_select && tick && !edge_wrap && !wr_count
        |=> timer_counter == $past(timer_counter) + 16'h0001)
        else $error("edge counter did not step by one");
    a_prescale_hold: assert property (
        clock_off |=> prescale_count == 7'h00)
        else $error("prescaler ran with no clock");
    a_drive_owned: assert property (
        (channel_pin_oe_o & ~channel_owns_pin_o) == 8'h00)
        else $error("pin driven without ownership");
    c_overflow: cover property (ovf_event);
    c_ext_tick: cover property (
        clock_source_select == tpc_pkg::CLKS_EXT && tick);
    c_flag_clear: cover property ($fell(event_flag[0]));
endmodule

/* File: tb/tpc_pin_model.sv */
`timescale 1ns/1ps
// Board side of the channel pins: loads and a level source per pin
module tpc_pin_model (
    input wire logic [7:0] pin_o_i, // Timer pin levels
    input wire logic [7:0] pin_oe_i, // Timer drive enables
    input wire logic [7:0] src_en_i, // Source drives the pin
    input wire logic [7:0] src_val_i, // Source level
    output logic [7:0] pin_o // Resolved pin level
);
    // Timer wins where it drives; idle pins float up to the pullup
    assign pin_o = (pin_oe_i & pin_o_i)
        | (~pin_oe_i & src_en_i & src_val_i)
        | (~pin_oe_i & ~src_en_i);
endmodule

/* File: tb/tpc_tb_top.sv */
`timescale 1ns/1ps
// Register-driven checks of the channel pin functions
module timer_channel_pin_control_tb_top;
    logic mclk_i = 1'b0; // Bus clock
    logic rst_n_i = 1'b0; // Reset, active low
    logic [7:0] address_i = 8'h00; // Bus address
    logic read_i = 1'b0; // Read strobe
    logic write_i = 1'b0; // Write strobe
    logic [31:0] writedata_i = 32'h0; // Write data
    logic [31:0] readdata_o; // Read data
    logic waitrequest_o; // Slave stall
    logic [7:0] pins; // Resolved pin levels
    logic [7:0] pin_o; // Timer pin levels
    logic [7:0] pin_oe; // Timer drive enables
    logic [7:0] owns; // Pin taken from port logic
    logic [7:0] flags; // Channel event flags
    logic [7:0] src_val = 8'h00; // Board source level
    logic ext_clk = 1'b0; // Own pin, no channel shares it
    logic [31:0] rd; // Last read value
    int failures = 0; // Mismatch count
    int samples_checked = 0; // Comparison count
    int n; // High-cycle count
    // Free-running 100 MHz clock
    always #5 mclk_i = ~mclk_i;
    tpc_top dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .address_i(address_i), .read_i(read_i), .write_i(write_i),
        .byteenable_i(4'hF), .writedata_i(writedata_i),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
        .fixed_clock_i(1'b0), .external_count_clock_pin_i(ext_clk),
        .channel_pin_i(pins), .channel_pin_o(pin_o),
        .channel_pin_oe_o(pin_oe), .channel_owns_pin_o(owns),
        .channel_event_flag_o(flags), .counter_overflow_flag_o());
    // Pin 2 held low by the source until the capture edge
    tpc_pin_model board (.pin_o_i(pin_o), .pin_oe_i(pin_oe),
        .src_en_i(8'h04), .src_val_i(src_val), .pin_o(pins));
    // Verdict and end of run
    task automatic stop_test();
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Compare and count
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One Avalon access; held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        @(posedge mclk_i);
        write_i <= wr;
        read_i <= !wr;
        address_i <= a;
        writedata_i <= d;
        k = 0;
        do begin
            @(posedge mclk_i);
            k++;
        end while (waitrequest_o !== 1'b0 && k < 50);
        // Answer taken at the edge that sees waitrequest low
        rd = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
        // A slave that never answers ends the run
        if (k >= 50) begin
            failures++;
            stop_test();
        end
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(negedge mclk_i);
        check("owns after reset", owns, 8'h00);
        check("oe after reset", pin_oe, 8'h00);
        bus(1'b0, 8'h60, 32'h0);
        check("unmapped read", rd, 32'h0);
        bus(1'b1, 8'h08, 32'h8);
        bus(1'b0, 8'h08, 32'h0);
        check("modulo readback", rd, 32'h8);
        bus(1'b1, 8'h14, 32'h5);
        bus(1'b1, 8'h10, 32'h28);
        bus(1'b1, 8'h1C, 32'h3);
        bus(1'b1, 8'h18, 32'h18);
        bus(1'b1, 8'h20, 32'h04);
        @(negedge mclk_i);
        check("owns clock off", owns, 8'h00);
        bus(1'b1, 8'h00, 32'h08);
        @(negedge mclk_i);
        check("owns modes", owns, 8'h07);
        check("oe modes", pin_oe, 8'h03);
        repeat (20) @(negedge mclk_i);
        check("compare clear", pin_o[1], 1'b0);
        n = 0;
        repeat (36) begin
            @(negedge mclk_i);
            n += int'(pin_o[0] === 1'b1);
        end
        check("pwm high count", n, 20);
        check("capture flag idle", flags[2], 1'b0);
        @(posedge mclk_i);
        src_val <= 8'h04;
        repeat (6) @(negedge mclk_i);
        check("capture flag", flags[2], 1'b1);
        bus(1'b1, 8'h00, 32'h28);
        @(negedge mclk_i);
        check("center oe", pin_oe, 8'h07);
        bus(1'b1, 8'h00, 32'h18);
        bus(1'b1, 8'h04, 32'h0);
        // Two cycles high, two low: quarter rate
        repeat (4) begin
            @(posedge mclk_i);
            ext_clk <= 1'b1;
            repeat (2) @(posedge mclk_i);
            ext_clk <= 1'b0;
            @(posedge mclk_i);
        end
        repeat (4) @(posedge mclk_i);
        bus(1'b0, 8'h04, 32'h0);
        check("ext count", rd, 32'h4);
        stop_test();
    end
endmodule
